// ---- dtio_pkg.sv ----
// Constants for the drive terminal input/output logic.
// Assumes frequencies arrive as unsigned counts of 0.01 Hz.
package dtio_pkg;
   // ****************************************
   // Field widths and ranges
   // ****************************************
   localparam int          FREQ_W         = 16;
   localparam int          CNT_W          = 14;
   localparam logic [13:0] CNT_MAX        = 14'h270f;   // 9999
   localparam logic [15:0] WIDTH_MAX      = 16'he9fc;   // 599.00 Hz
   localparam int          DI_N           = 5;
   localparam int          DO_N           = 3;
   localparam int          DI_FAST_IDX    = 4;
   localparam int          DO_FAST_IDX    = 1;
   localparam logic [1:0]  SYNC_WARM      = 2'h3;       // Edges before a pin reaches the count detector
   // ****************************************
   // Reset values and mode encodings
   // ****************************************
   localparam logic [4:0]  IN_POL_RST     = 5'h1f;
   localparam logic [4:0]  IN_POL2_RST    = 5'h1f;
   localparam logic [2:0]  OUT_POL_RST    = 3'h7;
   localparam logic [13:0] CNT_THR_RST    = 14'h0000;
   localparam logic [15:0] ARRIVAL_W_RST  = 16'h00fa;   // 2.50 Hz
   localparam logic        MODE_SWITCH    = 1'b0;
   localparam logic        MODE_PULSE     = 1'b1;
endpackage

// ---- dtio_terminal_io.sv ----
// Terminal input/output logic: arrival window, pulse counter, polarity.
// Assumes settings come from same-clock logic; terminal pins are asynchronous.
// Notes on behaviour
// - Frequency arrival is high while output frequency is within set frequency plus or minus the window width.
// - Input terminal five is a switch input in mode 0 and a fast pulse input in mode 1, default 0.
// - Output terminal two is a switch output in mode 0 and a fast pulse output in mode 1, default 0.
// - Set threshold spans specified threshold to 9999, specified spans zero to set, both reset to zero.
// - Pulses on the count trigger input are counted and set-count-reached rises when count equals set threshold; a zero set threshold never raises it.
// - Specified-count-reached rises at the specified threshold and holds until the set threshold is reached; a zero specified threshold never raises it.
// - A specified threshold above the set threshold is invalid and raises nothing.
// - Input polarity 1 means active when closed to common, 0 inverts it, all default 1.
// - Input polarity bits 0 to 4 serve input terminals one to five.
// - Output polarity bits 0 to 2 serve output one, output two and the relay, default 1.
// - The second input polarity setting is reserved and has no effect.
// - Output polarity 1 drives positive logic and 0 drives inverted logic.
module dtio_terminal_io #(
   parameter int DI_N = dtio_pkg::DI_N,
   parameter int DO_N = dtio_pkg::DO_N
) (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   // Frequency arrival
   input  wire logic [dtio_pkg::FREQ_W-1:0]   output_freq,
   input  wire logic [dtio_pkg::FREQ_W-1:0]   set_freq,
   input  wire logic [dtio_pkg::FREQ_W-1:0]   arrival_window_width,
   output logic                               frequency_arrival,
   // Terminal modes
   input  wire logic                          fast_in_mode,
   input  wire logic                          fast_out_mode,
   // Counter settings
   input  wire logic [dtio_pkg::CNT_W-1:0]    set_count_threshold,
   input  wire logic [dtio_pkg::CNT_W-1:0]    specified_count_threshold,
   input  wire logic [2:0]                    count_trigger_sel,
   output logic                               set_count_reached,
   output logic                               specified_count_reached,
   output logic [dtio_pkg::CNT_W-1:0]         pulse_count,
   // Polarity
   input  wire logic [4:0]                    input_polarity_setting,
   input  wire logic [4:0]                    input_polarity_setting_2,
   input  wire logic [2:0]                    output_polarity_setting,
   // Input terminals, high when closed to common
   input  wire logic [DI_N-1:0]               di_pins,
   output logic [DI_N-1:0]                    di_active,
   output logic                               fast_pulse_input_terminal,
   // Output terminals
   input  wire logic [DO_N-1:0]               do_func,
   input  wire logic                          fast_pulse_out_src,
   output logic [DO_N-1:0]                    do_pins,
   output logic                               fast_pulse_output_terminal
);
   // Bit wiring below serves five inputs and three outputs only
   if (DI_N != dtio_pkg::DI_N || DO_N != dtio_pkg::DO_N) begin : g_bad_size
      $error("dtio_terminal_io: terminal counts fixed at 5 inputs, 3 outputs");
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [DI_N-1:0] di_meta_reg;
   logic [DI_N-1:0] di_sync_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         di_meta_reg <= '0;
         di_sync_reg <= '0;
      end else begin
         di_meta_reg <= di_pins;
         di_sync_reg <= di_meta_reg;
      end
   end

   // ****************************************
   // Polarity and mode decoding
   // ****************************************
   // One polarity digit maps a contact level to an active level
   function automatic logic apply_pol(input logic pol, input logic lvl);
      return pol ? lvl : ~lvl;
   endfunction

   logic fast_in_pulse;
   logic fast_out_pulse;
   assign fast_in_pulse  = (fast_in_mode == dtio_pkg::MODE_PULSE);
   assign fast_out_pulse = (fast_out_mode == dtio_pkg::MODE_PULSE);

   // ****************************************
   // Input polarity and mode
   // ****************************************
   logic [DI_N-1:0] di_level;
   logic [DI_N-1:0] di_fast_mask;
   logic [DI_N-1:0] di_active_next;
   logic [DI_N-1:0] di_active_reg;
   logic            fast_in_reg;
   assign di_level     = di_sync_reg;
   // Pulse mode takes terminal five away from switch use
   assign di_fast_mask = {{(DI_N-1){1'b0}}, fast_in_pulse} << dtio_pkg::DI_FAST_IDX;
   genvar gi;
   generate
      for (gi = 0; gi < DI_N; gi++) begin : g_di
         // Bit gi serves terminal gi+1
         assign di_active_next[gi] = apply_pol(input_polarity_setting[gi], di_level[gi]);
      end
   endgenerate
   // Second polarity setting is deliberately unread
   wire unused_pol2 = ^input_polarity_setting_2;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         di_active_reg <= '0;
         fast_in_reg   <= 1'b0;
      end else begin
         di_active_reg <= di_active_next & ~di_fast_mask;
         fast_in_reg   <= fast_in_pulse & di_level[dtio_pkg::DI_FAST_IDX];
      end
   end
   assign di_active                 = di_active_reg;
   assign fast_pulse_input_terminal = fast_in_reg;

   // ****************************************
   // Frequency arrival window
   // ****************************************
   logic [dtio_pkg::FREQ_W:0] freq_diff;
   logic [dtio_pkg::FREQ_W-1:0] width_clamped;
   logic                      arrival_next;
   logic                      arrival_reg;
   assign freq_diff = (output_freq >= set_freq) ? {1'b0, output_freq - set_freq}
                                                : {1'b0, set_freq - output_freq};
   // Width beyond 599.00 Hz is clamped to the range top
   assign width_clamped = (arrival_window_width > dtio_pkg::WIDTH_MAX) ? dtio_pkg::WIDTH_MAX
                                                                         : arrival_window_width;
   assign arrival_next = (freq_diff <= {1'b0, width_clamped});
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arrival_reg <= 1'b0;
      end else begin
         arrival_reg <= arrival_next;
      end
   end
   assign frequency_arrival = arrival_reg;

   // ****************************************
   // Pulse counter
   // ****************************************
   logic [dtio_pkg::CNT_W-1:0] set_thr;
   logic [dtio_pkg::CNT_W-1:0] spec_thr;
   logic                       spec_valid;
   logic                       trig_level;
   logic                       trig_prev_reg;
   logic                       trig_edge;
   logic [1:0]                 warm_reg;
   logic                       warm_done;
   logic [dtio_pkg::CNT_W-1:0] cnt_reg;
   logic [dtio_pkg::CNT_W-1:0] cnt_next;
   logic                       set_hit_reg;
   logic                       spec_hold_reg;
   logic                       spec_hold_next;

   // Set threshold limited to 9999
   assign set_thr  = (set_count_threshold > dtio_pkg::CNT_MAX) ? dtio_pkg::CNT_MAX : set_count_threshold;
   assign spec_thr = specified_count_threshold;
   // Out-of-range specified value is invalid rather than clamped
   assign spec_valid = (spec_thr <= set_thr);

   assign trig_level = (count_trigger_sel < 3'(DI_N)) ? di_active_reg[count_trigger_sel] : 1'b0;
   assign trig_edge  = trig_level & ~trig_prev_reg;
   // Detector primed high until the pin pipeline fills: an inverted idle input is no pulse
   assign warm_done  = (warm_reg == dtio_pkg::SYNC_WARM);

   // Count holds at threshold; the next pulse wraps it to zero
   assign cnt_next = !trig_edge ? cnt_reg :
                     (cnt_reg >= set_thr) ? '0 :
                     cnt_reg + 14'h0001;

   // Hold from specified until set reached
   assign spec_hold_next = !spec_valid ? 1'b0 :
                           (cnt_next >= set_thr) ? 1'b0 :
                           (cnt_next >= spec_thr && spec_thr != '0) ? 1'b1 :
                           spec_hold_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trig_prev_reg <= 1'b1;
         warm_reg      <= 2'h0;
         cnt_reg       <= '0;
         set_hit_reg   <= 1'b0;
         spec_hold_reg <= 1'b0;
      end else begin
         trig_prev_reg <= trig_level | ~warm_done;
         warm_reg      <= warm_done ? warm_reg : warm_reg + 2'h1;
         cnt_reg       <= cnt_next;
         set_hit_reg   <= (cnt_next == set_thr) && (set_thr != '0);
         spec_hold_reg <= spec_hold_next;
      end
   end
   assign set_count_reached       = set_hit_reg;
   assign specified_count_reached = spec_hold_reg;
   assign pulse_count             = cnt_reg;

   // ****************************************
   // Output polarity and mode
   // ****************************************
   logic [DO_N-1:0] do_level;
   logic [DO_N-1:0] do_fast_mask;
   logic [DO_N-1:0] do_next;
   logic [DO_N-1:0] do_reg;
   logic            fast_out_reg;
   genvar go;
   generate
      for (go = 0; go < DO_N; go++) begin : g_do
         assign do_level[go] = apply_pol(output_polarity_setting[go], do_func[go]);
      end
   endgenerate
   // Pulse mode hands terminal two to the pulse source, bypassing polarity
   assign do_fast_mask = {{(DO_N-1){1'b0}}, fast_out_pulse} << dtio_pkg::DO_FAST_IDX;
   assign do_next      = (do_level & ~do_fast_mask) | ({DO_N{fast_pulse_out_src}} & do_fast_mask);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         do_reg       <= '0;
         fast_out_reg <= 1'b0;
      end else begin
         do_reg       <= do_next;
         fast_out_reg <= fast_out_pulse & fast_pulse_out_src;
      end
   end
   assign do_pins                    = do_reg;
   assign fast_pulse_output_terminal = fast_out_reg;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_trig_at_top;
      trig_edge && cnt_reg >= set_thr;
   endsequence
   sequence s_warming;
      !warm_done;
   endsequence

   a_arrival_window: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> frequency_arrival == $past(arrival_next))
      else $error("arrival flag does not follow window compare");
   a_fast_in_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      (fast_in_mode == dtio_pkg::MODE_SWITCH) |=> !fast_pulse_input_terminal)
      else $error("pulse input active in switch mode");
   a_fast_out_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      (fast_out_mode == dtio_pkg::MODE_SWITCH) |=> do_pins[1] == $past(do_level[1]))
      else $error("output two not switch in mode 0");
   a_count_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      pulse_count <= dtio_pkg::CNT_MAX)
      else $error("count beyond 9999");
   a_set_reached: assert property (@(posedge mclk) disable iff (!rst_n)
      (cnt_next == set_thr && set_thr != '0) |=> set_count_reached)
      else $error("set count reached not raised");
   a_spec_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      specified_count_reached |-> pulse_count < set_thr)
      else $error("specified flag held past set count");
   a_spec_invalid: assert property (@(posedge mclk) disable iff (!rst_n)
      !spec_valid |=> !specified_count_reached)
      else $error("invalid specified threshold raised flag");
   a_in_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
      (input_polarity_setting[0] == 1'b0) |=> di_active[0] == !$past(di_sync_reg[0]))
      else $error("input one polarity inversion wrong");
   a_out_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
      (output_polarity_setting[0] == 1'b1) |=> do_pins[0] == $past(do_func[0]))
      else $error("output one positive logic wrong");
   a_counter_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
      s_trig_at_top |=> pulse_count == '0)
      else $error("counter did not restart");

   // ****************************************
   // Edge, level and polarity checks
   // ****************************************
   a_arrival_exact: assert property (@(posedge mclk) disable iff (!rst_n)
      (output_freq == set_freq) |=> frequency_arrival)
      else $error("arrival flag low at exact set frequency");
   a_fast_in_mask: assert property (@(posedge mclk) disable iff (!rst_n)
      fast_in_pulse |=> !di_active[dtio_pkg::DI_FAST_IDX])
      else $error("terminal five active as switch in pulse mode");
   a_fast_out_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      fast_out_pulse |=> do_pins[dtio_pkg::DO_FAST_IDX] == $past(fast_pulse_out_src))
      else $error("output two not following pulse source");
   a_set_level: assert property (@(posedge mclk) disable iff (!rst_n)
      set_count_reached |-> pulse_count == $past(set_thr))
      else $error("set count flag away from set count");
   a_no_trigger: assert property (@(posedge mclk) disable iff (!rst_n)
      (count_trigger_sel >= 3'(DI_N)) |=> pulse_count == $past(pulse_count))
      else $error("count moved with no trigger selected");
   a_warm_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      s_warming |-> !trig_edge)
      else $error("trigger edge taken before synchroniser filled");
   a_spec_rise: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(specified_count_reached) |-> pulse_count >= $past(spec_thr) && $past(spec_thr) != '0)
      else $error("specified flag rose below specified count");
   a_spec_at_set: assert property (@(posedge mclk) disable iff (!rst_n)
      (pulse_count == $past(set_thr)) |-> !specified_count_reached)
      else $error("specified flag high at set count");
   a_in_five_pol: assert property (@(posedge mclk) disable iff (!rst_n)
      (input_polarity_setting[4] && !fast_in_pulse) |=> di_active[4] == $past(di_sync_reg[4]))
      else $error("input five positive logic wrong");
   a_relay_pol: assert property (@(posedge mclk) disable iff (!rst_n)
      (output_polarity_setting[2] == 1'b0) |=> do_pins[2] == !$past(do_func[2]))
      else $error("relay negative logic wrong");
   a_out_two_pol: assert property (@(posedge mclk) disable iff (!rst_n)
      (output_polarity_setting[1] == 1'b0 && !fast_out_pulse) |=> do_pins[1] == !$past(do_func[1]))
      else $error("output two negative logic wrong");
endmodule

// ---- dtio_switches.sv ----
// External switch contacts on the five input terminals.
// Assumes the bench clock; a closed contact reads high.
module dtio_switches (
   // Clock
   input  wire logic mclk,
   // Terminals
   output logic [4:0] di_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial di_pins = 5'h00;
   // Contacts move only at falling edges
   task automatic set_all(input logic [4:0] v);
      @(negedge mclk);
      di_pins = v;
   endtask
   // Low time kept long so every pulse is seen
   task automatic pulse(input int i);
      @(negedge mclk);
      di_pins[i] = 1'b1;
      repeat (4) @(negedge mclk);
      di_pins[i] = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
endmodule

// ---- dtio_terminal_io_test.sv ----
// Self-checking bench for the terminal logic with a reference model.
// Assumes one 200 MHz clock and the switch model beside the design.
module dtio_terminal_io_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] output_freq = 16'h0000, set_freq = 16'h0000, arrival_window_width = 16'h0000;
   logic fast_in_mode = 1'b0, fast_out_mode = 1'b0, fast_pulse_out_src = 1'b0;
   logic [13:0] set_count_threshold = 14'h0000, specified_count_threshold = 14'h0000;
   logic [2:0] count_trigger_sel = 3'h7, output_polarity_setting = 3'h7, do_func = 3'h0;
   logic [4:0] input_polarity_setting = 5'h1f, input_polarity_setting_2 = 5'h1f;
   logic frequency_arrival, set_count_reached, specified_count_reached;
   logic fast_pulse_input_terminal, fast_pulse_output_terminal;
   logic [13:0] pulse_count;
   logic [4:0] di_pins, di_active, exp_di;
   logic [2:0] do_pins, exp_do;
   logic [31:0] seed = 32'ha9a7;
   int miscompares = 0;
   int tests_run = 0;
   int s, w, o, st, sp, cnt;
   int st_tab[4] = '{8, 8, 4, 6};
   int sp_tab[4] = '{5, 9, 4, 0};
   always #2.5 mclk = ~mclk;
   dtio_terminal_io uut (.mclk, .rst_n, .output_freq, .set_freq, .arrival_window_width, .frequency_arrival,
      .fast_in_mode, .fast_out_mode, .set_count_threshold, .specified_count_threshold, .count_trigger_sel,
      .set_count_reached, .specified_count_reached, .pulse_count, .input_polarity_setting,
      .input_polarity_setting_2, .output_polarity_setting, .di_pins, .di_active, .fast_pulse_input_terminal,
      .do_func, .fast_pulse_out_src, .do_pins, .fast_pulse_output_terminal);
   dtio_switches sw (.mclk, .di_pins);
   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_vec(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run;
      $display("Checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Cuts a hang short
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (5) @(negedge mclk);
      chk_bit("arrival_in_reset", 1'b0, frequency_arrival);
      rst_n = 1'b1;
      // Window edges, clamp just above the top width
      for (int k = 0; k < 30; k++) begin
         seed = lfsr_next(seed);
         s = 59918 + seed[4:0];
         w = (k < 4) ? 59900 + k % 2 : seed[27:16];
         o = (k >= 4 && k % 2) ? s + w + k % 3 - 1 : s - (w > 59900 ? 59900 : w) + k % 3 - 1;
         set_freq = 16'(s);
         arrival_window_width = 16'(w);
         output_freq = 16'(o);
         repeat (2) @(negedge mclk);
         chk_bit("arrival", (o > s ? o - s : s - o) <= (w > 59900 ? 59900 : w), frequency_arrival);
      end
      // Polarity and modes; no trigger selected so nothing counts
      for (int k = 0; k < 30; k++) begin
         seed = lfsr_next(seed);
         sw.set_all(seed[23:19]);
         {fast_pulse_out_src, fast_out_mode, fast_in_mode, do_func} = seed[18:13];
         {output_polarity_setting, input_polarity_setting_2, input_polarity_setting} = seed[12:0];
         repeat (5) @(negedge mclk);
         exp_di = seed[23:19] ~^ seed[4:0];
         exp_di[4] = exp_di[4] & ~seed[16];
         exp_do = seed[15:13] ~^ seed[12:10];
         exp_do[1] = seed[17] ? seed[18] : exp_do[1];
         chk_vec("di_active", {11'h000, exp_di}, {11'h000, di_active});
         chk_bit("fast_in", seed[16] & seed[23], fast_pulse_input_terminal);
         chk_vec("do_pins", {13'h0000, exp_do}, {13'h0000, do_pins});
         chk_bit("fast_out", seed[17] & seed[18], fast_pulse_output_terminal);
      end
      chk_vec("idle_count", 16'h0000, {2'b00, pulse_count});
      // Threshold pairs, each after a mid-run reset
      {fast_in_mode, input_polarity_setting} = 6'h1f;
      sw.set_all(5'h00);
      for (int p = 0; p < 4; p++) begin
         st = st_tab[p];
         sp = sp_tab[p];
         rst_n = 1'b0;
         set_count_threshold = 14'(st);
         specified_count_threshold = 14'(sp);
         count_trigger_sel = 3'(p + 1);
         // Last pair idles its trigger active, so a false edge after reset would count
         input_polarity_setting = (p == 3) ? 5'h0f : 5'h1f;
         repeat (2) @(negedge mclk);
         rst_n = 1'b1;
         cnt = 0;
         for (int n = 0; n < 2 * st + 3; n++) begin
            sw.pulse(p + 1);
            cnt = (cnt == st) ? 0 : cnt + 1;
            chk_vec("count", 16'(cnt), {2'b00, pulse_count});
            chk_bit("set_reached", cnt == st, set_count_reached);
            chk_bit("spec_reached", sp != 0 && sp <= cnt && cnt < st, specified_count_reached);
         end
      end
      complete_run();
   end
endmodule
